// [dma_ctrl.v]
// dual channel dma controller with axi4-lite register slave and local bus master
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dma_ctrl_defines.vh"

// Operation
// - two independent channels, any space to any space
// - byte or word moves, 20-bit pointers
// - fetch cycle then store cycle, eight clocks minimum
// - six 16-bit registers per channel
// - counter sets transfers, up to 64K
// - register writes act at once on channel
// - control writes affect the transfer under way
// - bit 15 selects destination memory or io
// - destination steps down or up by size
// - bit 12 source space, source steps by size
// - both step flags set keeps pointer fixed
// - stop at zero clears run bit on zero
// - interrupt request at terminal count when enabled; code raises it only with stop at zero set or free pacing
// - pacing select: free, source, destination, unused
// - priority bit ranks channels on simultaneous requests
// - bit 0 selects word unless narrow bus
// - run bit written only with mask bit set
// - equal priority channels alternate transfer cycles
// - timer request enable admits third timer requests
// - reset stops channels and aborts transfers
module dma_ctrl (
  // clock and reset
  input  wire        mclk,
  input  wire        srst,
  // axi4-lite write address
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // transfer requests and strap
  input  wire [1:0]  transferRequest,
  input  wire        timerRequest,
  input  wire        narrowBus,
  // local bus master
  output reg         busActive,
  output reg  [19:0] busAddr,
  output reg         busIsMem,
  output reg         busWord,
  output reg         busRdStrobe,
  output reg         busWrStrobe,
  output reg  [15:0] busWdata,
  input  wire [15:0] busRdata,
  input  wire        busReady,
  // interrupt requests to the processor
  output reg  [1:0]  irqReq
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_F1   = 4'h1;
  localparam [3:0] ST_F2   = 4'h2;
  localparam [3:0] ST_F3   = 4'h3;
  localparam [3:0] ST_F4   = 4'h4;
  localparam [3:0] ST_S1   = 4'h5;
  localparam [3:0] ST_S2   = 4'h6;
  localparam [3:0] ST_S3   = 4'h7;
  localparam [3:0] ST_S4   = 4'h8;
  localparam [3:0] ST_GAP  = 4'h9;

  // per channel storage, indexed by channel number
  reg  [19:0] src_r [0:1];
  reg  [19:0] dst_r [0:1];
  reg  [15:0] cnt_r [0:1];
  reg  [15:0] ctl_r [0:1];

  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg         cur_r;
  reg         last_r;
  reg  [1:0]  gap_r;
  reg  [15:0] data_r;
  reg         awHave_r;
  reg         wHave_r;
  reg  [31:0] awAddr_r;
  reg  [31:0] wData_r;
  reg  [3:0]  wStrb_r;

  // returns {hit, channel, select}
  function [4:0] regDecode;
    input [31:0] a;
    integer ch;
    integer k;
    begin
      regDecode = 5'h00;
      for (ch = 0; ch < 2; ch = ch + 1) begin
        for (k = 0; k < 6; k = k + 1) begin
          if (a[31:10] == 22'h000000 && a[1:0] == 2'h0 &&
              a[9:2] == `IDX_CH0_SRC_LO + ch[7:0] * `IDX_CH_STRIDE + 8'h02 * k[7:0]) begin
            regDecode = {1'b1, ch[0], k[2:0]};
          end
        end
      end
    end
  endfunction

  // pointer stepping: both flags or none leave it alone
  function [19:0] stepPtr;
    input [19:0] p;
    input        up;
    input        down;
    input        word;
    reg   [19:0] inc;
    begin
      inc = word ? 20'h00002 : 20'h00001;
      if (up && !down) begin
        stepPtr = p + inc;
      end else if (down && !up) begin
        stepPtr = p - inc;
      end else begin
        stepPtr = p;
      end
    end
  endfunction

  // byte lane merge for 16-bit halves
  function [15:0] laneMerge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  strb;
    begin
      laneMerge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // channel wants a transfer now
  function chanReady;
    input [15:0] ctl;
    input        transfer_request;
    input        tmr;
    reg   [1:0]  pace;
    reg          req;
    begin
      pace = ctl[`CW_PACE_HI:`CW_PACE_LO];
      req  = transfer_request | (tmr & ctl[`CW_TIMER_REQ_EN]);
      chanReady = ctl[`CW_RUN] &&
                  (pace == `PACE_FREE || ((pace == `PACE_SRC || pace == `PACE_DST) && req));
    end
  endfunction

  wire [4:0]  wDec = regDecode(awAddr_r);
  wire [4:0]  rDec = regDecode(s_axi_araddr);
  wire        regWr = awHave_r && wHave_r && !s_axi_bvalid;
  wire        wCh   = wDec[3];
  wire        rCh   = rDec[3];

  wire        rdy0  = chanReady(ctl_r[0], transferRequest[0], timerRequest);
  wire        rdy1  = chanReady(ctl_r[1], transferRequest[1], timerRequest);
  wire        pri0  = ctl_r[0][`CW_PRIORITY];
  wire        pri1  = ctl_r[1][`CW_PRIORITY];

  // pick channel 1 when channel 0 is not ready, when it outranks, or when it is its turn
  wire        pick1 = rdy1 && (!rdy0 || (pri1 && !pri0) ||
                               (pri1 == pri0 && !last_r));

  // live control word of the running channel: a mid transfer write changes this transfer
  wire [15:0] curCtl  = ctl_r[cur_r];
  wire        curWord = curCtl[`CW_WORD] & ~narrowBus;
  wire [15:0] cntDec  = cnt_r[cur_r] - 16'h0001;
  wire        curFree = curCtl[`CW_PACE_HI:`CW_PACE_LO] == `PACE_FREE;
  wire        endXfer = state_r == ST_S4;
  wire        hwStop  = endXfer && cntDec == 16'h0000 &&
                        (curCtl[`CW_STOP_AT_ZERO] || curFree);

  assign s_axi_awready = !awHave_r && !s_axi_bvalid;
  assign s_axi_wready  = !wHave_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // write channel capture; address and data may arrive in either order
  always @(posedge mclk) begin
    if (srst) begin
      awHave_r     <= 1'b0;
      wHave_r      <= 1'b0;
      awAddr_r     <= 32'h00000000;
      wData_r      <= 32'h00000000;
      wStrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (regWr) begin
        awHave_r     <= 1'b0;
        wHave_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wDec[4] ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel; registers are 16 bits wide, upper half reads zero
  always @(posedge mclk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rDec[4] ? `RESP_OKAY : `RESP_SLVERR;
      case (rDec[2:0])
        `SEL_SRC_LO: s_axi_rdata <= {16'h0000, src_r[rCh][15:0]};
        `SEL_SRC_HI: s_axi_rdata <= {28'h0000000, src_r[rCh][19:16]};
        `SEL_DST_LO: s_axi_rdata <= {16'h0000, dst_r[rCh][15:0]};
        `SEL_DST_HI: s_axi_rdata <= {28'h0000000, dst_r[rCh][19:16]};
        `SEL_COUNT:  s_axi_rdata <= {16'h0000, cnt_r[rCh]};
        `SEL_CTRL:   s_axi_rdata <= {16'h0000, ctl_r[rCh] & `CW_STORED_MASK};
        default:     s_axi_rdata <= 32'h00000000;
      endcase
      if (!rDec[4]) begin
        s_axi_rdata <= 32'h00000000;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // channel registers: hardware steps at the end of a store, a software write
  // in the same cycle wins since it is the newer intent
  always @(posedge mclk) begin : chanRegs
    integer ch;
    reg     runNew;
    runNew = 1'b0;
    if (srst) begin
      for (ch = 0; ch < 2; ch = ch + 1) begin
        src_r[ch] <= 20'h00000;
        dst_r[ch] <= 20'h00000;
        cnt_r[ch] <= 16'h0000;
        ctl_r[ch] <= `CW_RESET;
      end
    end else begin
      if (endXfer) begin
        src_r[cur_r] <= stepPtr(src_r[cur_r], curCtl[`CW_SRC_UP],
                                curCtl[`CW_SRC_DOWN], curWord);
        dst_r[cur_r] <= stepPtr(dst_r[cur_r], curCtl[`CW_DST_UP],
                                curCtl[`CW_DST_DOWN], curWord);
        cnt_r[cur_r] <= cntDec;
        if (hwStop) begin
          ctl_r[cur_r][`CW_RUN] <= 1'b0;
        end
      end
      if (regWr && wDec[4]) begin
        case (wDec[2:0])
          `SEL_SRC_LO: src_r[wCh][15:0]  <= laneMerge(src_r[wCh][15:0], wData_r[15:0],
                                                      wStrb_r[1:0]);
          `SEL_SRC_HI: if (wStrb_r[0]) src_r[wCh][19:16] <= wData_r[3:0];
          `SEL_DST_LO: dst_r[wCh][15:0]  <= laneMerge(dst_r[wCh][15:0], wData_r[15:0],
                                                      wStrb_r[1:0]);
          `SEL_DST_HI: if (wStrb_r[0]) dst_r[wCh][19:16] <= wData_r[3:0];
          `SEL_COUNT:  cnt_r[wCh] <= laneMerge(cnt_r[wCh], wData_r[15:0], wStrb_r[1:0]);
          `SEL_CTRL: begin
            if (wStrb_r[0] && wData_r[`CW_RUN_MASK]) begin
              runNew = wData_r[`CW_RUN];
            end else begin
              runNew = ctl_r[wCh][`CW_RUN] & ~(hwStop && cur_r == wCh);
            end
            ctl_r[wCh] <= (laneMerge(ctl_r[wCh], wData_r[15:0], wStrb_r[1:0]) &
                           `CW_STORED_MASK & ~16'h0002) | {14'h0000, runNew, 1'b0};
          end
          default: ;
        endcase
      end
    end
  end

  // transfer sequencer: four clocks fetch, four clocks store, wait in third clock
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (rdy0 || rdy1) begin
          state_nxt = ST_F1;
        end
      end
      ST_F1: state_nxt = ST_F2;
      ST_F2: state_nxt = ST_F3;
      ST_F3: begin
        if (busReady) begin
          state_nxt = ST_F4;
        end
      end
      ST_F4: state_nxt = ST_S1;
      ST_S1: state_nxt = ST_S2;
      ST_S2: state_nxt = ST_S3;
      ST_S3: begin
        if (busReady) begin
          state_nxt = ST_S4;
        end
      end
      ST_S4: begin
        if (curCtl[`CW_PACE_HI:`CW_PACE_LO] == `PACE_DST) begin
          state_nxt = ST_GAP;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_GAP: begin
        if (gap_r == 2'h1) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      cur_r   <= 1'b0;
      last_r  <= 1'b1;
      gap_r   <= 2'h0;
      data_r  <= 16'h0000;
      irqReq  <= 2'h0;
    end else begin
      state_r <= state_nxt;
      irqReq  <= 2'h0;
      if (state_r == ST_IDLE && (rdy0 || rdy1)) begin
        cur_r  <= pick1;
        last_r <= pick1;
      end
      if (state_r == ST_S4) begin
        gap_r <= `DST_GAP_CLOCKS; // the peripheral gets time to drop its request
      end else if (gap_r != 2'h0) begin
        gap_r <= gap_r - 2'h1;
      end
      // odd addresses fetch from the high lane of a wide bus
      if (state_r == ST_F3 && busReady) begin
        if (curWord) begin
          data_r <= busRdata;
        end else if (busAddr[0] && !narrowBus) begin
          data_r <= {busRdata[15:8], busRdata[15:8]};
        end else begin
          data_r <= {busRdata[7:0], busRdata[7:0]};
        end
      end
      if (hwStop && curCtl[`CW_IRQ_EN]) begin
        irqReq[cur_r] <= 1'b1;
      end
    end
  end

  // bus outputs; pointers and spaces are read live so software changes apply at once
  always @(posedge mclk) begin
    if (srst) begin
      busActive   <= 1'b0;
      busAddr     <= 20'h00000;
      busIsMem    <= 1'b0;
      busWord     <= 1'b0;
      busRdStrobe <= 1'b0;
      busWrStrobe <= 1'b0;
      busWdata    <= 16'h0000;
    end else begin
      busActive   <= (state_nxt >= ST_F1 && state_nxt <= ST_S4);
      busRdStrobe <= (state_nxt == ST_F2 || state_nxt == ST_F3);
      busWrStrobe <= (state_nxt == ST_S2 || state_nxt == ST_S3);
      if (state_nxt == ST_F1) begin
        busAddr  <= (state_r == ST_IDLE) ? src_r[pick1] : src_r[cur_r];
        busIsMem <= (state_r == ST_IDLE) ? ctl_r[pick1][`CW_SRC_MEM] : curCtl[`CW_SRC_MEM];
        busWord  <= (state_r == ST_IDLE) ? (ctl_r[pick1][`CW_WORD] & ~narrowBus) : curWord;
      end else if (state_nxt == ST_S1) begin
        busAddr  <= dst_r[cur_r];
        busIsMem <= curCtl[`CW_DST_MEM];
        busWord  <= curWord;
        busWdata <= data_r;
      end
    end
  end
endmodule

// [dma_ctrl_defines.vh]
// register indices, control word fields and timing counts for the dual channel dma block
`ifndef DMA_CTRL_DEFINES_VH
`define DMA_CTRL_DEFINES_VH

// register indices; byte address on the bus is four times the index
`define IDX_CH0_SRC_LO   8'hc0
`define IDX_CH0_SRC_HI   8'hc2
`define IDX_CH0_DST_LO   8'hc4
`define IDX_CH0_DST_HI   8'hc6
`define IDX_CH0_COUNT    8'hc8
`define IDX_CH0_CTRL     8'hca
`define IDX_CH1_SRC_LO   8'hd0
`define IDX_CH1_SRC_HI   8'hd2
`define IDX_CH1_DST_LO   8'hd4
`define IDX_CH1_DST_HI   8'hd6
`define IDX_CH1_COUNT    8'hd8
`define IDX_CH1_CTRL     8'hda
`define IDX_CH_STRIDE    8'h10

// register select codes within one channel
`define SEL_SRC_LO       3'h0
`define SEL_SRC_HI       3'h1
`define SEL_DST_LO       3'h2
`define SEL_DST_HI       3'h3
`define SEL_COUNT        3'h4
`define SEL_CTRL         3'h5

// control word fields
`define CW_DST_MEM       15
`define CW_DST_DOWN      14
`define CW_DST_UP        13
`define CW_SRC_MEM       12
`define CW_SRC_DOWN      11
`define CW_SRC_UP        10
`define CW_STOP_AT_ZERO  9
`define CW_IRQ_EN        8
`define CW_PACE_HI       7
`define CW_PACE_LO       6
`define CW_PRIORITY      5
`define CW_TIMER_REQ_EN  4
`define CW_RUN_MASK      2
`define CW_RUN           1
`define CW_WORD          0
`define CW_STORED_MASK   16'hfff3
`define CW_RESET         16'h0000

// pacing select encodings
`define PACE_FREE        2'h0
`define PACE_SRC         2'h1
`define PACE_DST         2'h2
`define PACE_UNUSED      2'h3

// idle clocks after a destination paced transfer
`define DST_GAP_CLOCKS   2'h2

// axi answers
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// [dma_ctrl_checker.sv]
// concurrent checks on the dma controller ports
`timescale 1ns/1ps
module dma_ctrl_checker (
  // clock and reset
  input wire        mclk,
  input wire        srst,
  // register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // local bus
  input wire        busActive,
  input wire [19:0] busAddr,
  input wire        busRdStrobe,
  input wire        busWrStrobe,
  input wire        busReady,
  input wire [1:0]  irqReq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  xfer_length_a: assert property ($rose(busActive) |-> busActive [*8])
    else $error("transfer shorter than eight clocks");
  fetch_first_a: assert property ($rose(busActive) |=> busRdStrobe)
    else $error("transfer did not open with a fetch");
  strobe_excl_a: assert property ((busRdStrobe || busWrStrobe) |->
    busActive && !(busRdStrobe && busWrStrobe))
    else $error("bus strobes overlap or stray");
  wait_hold_a: assert property (busRdStrobe && !busReady |=> busRdStrobe && $stable(busAddr))
    else $error("fetch left before ready");
  irq_pulse_a: assert property ((irqReq != 2'h0) |=> (irqReq == 2'h0))
    else $error("interrupt request longer than one clock");
  irq_end_a: assert property ((irqReq != 2'h0) |-> !busActive && $past(busActive))
    else $error("interrupt request not at end of transfer");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule

// [local_bus_model.sv]
// memory and io device model on the local bus, with wait states
`timescale 1ns/1ps
module local_bus_model (
  // clock and reset
  input  wire        mclk,
  input  wire        srst,
  // local bus
  input  wire [19:0] busAddr,
  input  wire        busIsMem,
  input  wire        busRdStrobe,
  input  wire        busWrStrobe,
  input  wire [15:0] busWdata,
  output reg  [15:0] busRdata,
  output wire        busReady,
  // control and observation
  input  wire [3:0]  waitStates,
  output reg  [19:0] lastAddr,
  output reg  [15:0] lastData,
  output reg         lastMem,
  output reg  [31:0] writes
);
  reg [3:0] cnt_r;
  reg       prevWr_r;
  assign busReady = (cnt_r >= waitStates);
  always @(posedge mclk) begin
    cnt_r <= (busRdStrobe || busWrStrobe) ? ((cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1) : 4'h0;
    // outside a fetch the lines wander so stale data never looks valid
    busRdata <= busRdStrobe ? (busAddr[15:0] ^ 16'h5a3c) : ~busRdata;
    prevWr_r <= busWrStrobe;
    if (busWrStrobe) begin
      lastAddr <= busAddr;
      lastData <= busWdata;
      lastMem <= busIsMem;
    end
    if (srst)
      writes <= 32'h0;
    else if (prevWr_r && !busWrStrobe)
      writes <= writes + 32'h1;
  end
  initial begin
    busRdata = 16'h0;
    cnt_r = 4'h0;
    prevWr_r = 1'b0;
  end
endmodule

// [dma_ctrl_tb_top.sv]
// self-checking bench for the dual channel dma controller
`timescale 1ns/1ps
`include "dma_ctrl_defines.vh"
module dma_ctrl_tb_top;
  reg         mclk = 1'b0, srst = 1'b1, narrowBus = 1'b0;
  reg  [31:0] awAddr = 32'h0, wData = 32'h0, arAddr = 32'h0, rdData;
  reg         awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  reg  [1:0]  transferRequest = 2'h0, lastResp;
  reg  [3:0]  waitStates = 4'h0;
  reg         timerRequest = 1'b0, lastWord = 1'b0;
  wire        awReady, wReady, bValid, arReady, rValid, busActive, busIsMem, busWord;
  wire        busRdStrobe, busWrStrobe, busReady, lastMem;
  wire [1:0]  bResp, rResp, irqReq;
  wire [31:0] rData, writes;
  wire [19:0] busAddr, lastAddr;
  wire [15:0] busWdata, busRdata, lastData;
  integer     failures = 0, checks = 0, irq0 = 0, irq1 = 0;

  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (irqReq[0]) irq0 <= irq0 + 1;
    if (irqReq[1]) irq1 <= irq1 + 1;
    if (busWrStrobe) lastWord <= busWord;
  end

  dma_ctrl DUT (.mclk(mclk), .srst(srst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'h3), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .transferRequest(transferRequest), .timerRequest(timerRequest), .narrowBus(narrowBus),
    .busActive(busActive), .busAddr(busAddr), .busIsMem(busIsMem), .busWord(busWord),
    .busRdStrobe(busRdStrobe), .busWrStrobe(busWrStrobe), .busWdata(busWdata),
    .busRdata(busRdata), .busReady(busReady), .irqReq(irqReq));

  local_bus_model partner (.mclk(mclk), .srst(srst), .busAddr(busAddr), .busIsMem(busIsMem),
    .busRdStrobe(busRdStrobe), .busWrStrobe(busWrStrobe), .busWdata(busWdata),
    .busRdata(busRdata), .busReady(busReady), .waitStates(waitStates), .lastAddr(lastAddr),
    .lastData(lastData), .lastMem(lastMem), .writes(writes));

  task complete_run;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  task hang;
    begin
      failures = failures + 1;
      $display("[FAIL] wait expected done seen timeout");
      complete_run;
    end
  endtask

  task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // address and data go out together; each drops on its own handshake
  task wr(input [7:0] idx, input [15:0] d);
    integer n;
    begin
      @(posedge mclk);
      awAddr <= {22'h0, idx, 2'h0};
      wData <= {16'h0, d};
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      n = 0;
      do begin
        @(posedge mclk);
        n = n + 1;
        if (n > 100) hang;
        if (awValid && awReady) awValid <= 1'b0;
        if (wValid && wReady) wValid <= 1'b0;
      end while (!(bValid && !awValid && !wValid));
      lastResp = bResp;
      bReady <= 1'b0;
    end
  endtask

  task rd(input [7:0] idx);
    integer n;
    begin
      @(posedge mclk);
      arAddr <= {22'h0, idx, 2'h0};
      arValid <= 1'b1;
      rReady <= 1'b1;
      n = 0;
      do begin
        @(posedge mclk);
        n = n + 1;
        if (n > 100) hang;
        if (arValid && arReady) arValid <= 1'b0;
      end while (!(rValid && !arValid));
      rdData = rData;
      lastResp = rResp;
      rReady <= 1'b0;
    end
  endtask

  task rdChk(input string what, input [7:0] idx, input [15:0] exp);
    begin
      rd(idx);
      check(what, rdData, {16'h0, exp});
    end
  endtask

  task setCh(input [7:0] b, input [19:0] s, input [19:0] d, input [15:0] c, input [15:0] w);
    begin
      wr(b, s[15:0]);
      wr(b + 8'h2, {12'h0, s[19:16]});
      wr(b + 8'h4, d[15:0]);
      wr(b + 8'h6, {12'h0, d[19:16]});
      wr(b + 8'h8, c);
      wr(b + 8'ha, w);
    end
  endtask

  // the extra clocks let the stop and the interrupt pulse land
  task waitWrites(input integer target);
    integer n;
    begin
      n = 0;
      while (writes < target) begin
        @(posedge mclk);
        n = n + 1;
        if (n > 2000) hang;
      end
      repeat (4) @(posedge mclk);
    end
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    rdChk("ch1 ctrl reset", `IDX_CH1_CTRL, 16'h0000);
    wr(8'h40, 16'h1234);
    check("unmapped wr resp", {30'h0, lastResp}, {30'h0, `RESP_SLVERR});
    rd(8'h40);
    check("unmapped rd resp", {30'h0, lastResp}, {30'h0, `RESP_SLVERR});
    check("unmapped rd data", rdData, 32'h0);
    // free running word copy, memory to memory, both pointers up
    setCh(`IDX_CH0_SRC_LO, 20'h12340, 20'h25670, 16'h2, 16'hb507);
    waitWrites(2);
    check("stores", writes, 32'h2);
    check("store addr", {12'h0, lastAddr}, 32'h25672);
    check("store data", {16'h0, lastData}, 32'h797e);
    check("store space", {31'h0, lastMem}, 32'h1);
    check("store word", {31'h0, lastWord}, 32'h1);
    check("ch0 irq", irq0, 1);
    rdChk("ch0 src lo", `IDX_CH0_SRC_LO, 16'h2344);
    rdChk("ch0 src hi", `IDX_CH0_SRC_HI, 16'h0001);
    rdChk("ch0 dst lo", `IDX_CH0_DST_LO, 16'h5674);
    rdChk("ch0 count", `IDX_CH0_COUNT, 16'h0000);
    rdChk("ch0 ctrl", `IDX_CH0_CTRL, 16'hb501);
    // source paced byte copy in io space, source fixed, slow partner
    waitStates <= 4'h2;
    timerRequest <= 1'b1;
    setCh(`IDX_CH1_SRC_LO, 20'h00100, 20'h00201, 16'h2, 16'h4e46);
    repeat (20) @(posedge mclk);
    check("paced idle", writes, 32'h2);
    transferRequest <= 2'h2;
    waitWrites(4);
    transferRequest <= 2'h0;
    check("ch1 store addr", {12'h0, lastAddr}, 32'h00200);
    check("ch1 store data", {16'h0, lastData}, 32'h3c3c);
    check("ch1 space", {31'h0, lastMem}, 32'h0);
    check("ch1 store word", {31'h0, lastWord}, 32'h0);
    check("ch1 irq", irq1, 0);
    rdChk("ch1 src lo", `IDX_CH1_SRC_LO, 16'h0100);
    rdChk("ch1 dst lo", `IDX_CH1_DST_LO, 16'h01ff);
    rdChk("ch1 ctrl", `IDX_CH1_CTRL, 16'h4e40);
    // run bit ignored without the write mask
    waitStates <= 4'h0;
    wr(`IDX_CH0_CTRL, 16'hb503);
    repeat (20) @(posedge mclk);
    check("masked start", writes, 32'h4);
    rdChk("ch0 ctrl masked", `IDX_CH0_CTRL, 16'hb501);
    // narrow bus forces bytes even with the word bit set
    narrowBus <= 1'b1;
    wr(`IDX_CH0_COUNT, 16'h0001);
    wr(`IDX_CH0_CTRL, 16'hb507);
    waitWrites(5);
    check("narrow data", {16'h0, lastData}, 32'h7878);
    check("narrow word", {31'h0, lastWord}, 32'h0);
    rdChk("narrow dst lo", `IDX_CH0_DST_LO, 16'h5675);
    check("ch0 irq again", irq0, 2);
    // the timer request paces channel 1 once its enable bit is set
    wr(`IDX_CH1_COUNT, 16'h0001);
    wr(`IDX_CH1_CTRL, 16'h4e56);
    waitWrites(6);
    check("timer store addr", {12'h0, lastAddr}, 32'h001ff);
    check("timer store data", {16'h0, lastData}, 32'h3c3c);
    // a reset in mid transfer aborts it and stops the channel
    waitStates <= 4'h8;
    wr(`IDX_CH0_CTRL, 16'hb507);
    repeat (3) @(posedge mclk);
    check("busy before reset", {31'h0, busActive}, 32'h1);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    check("aborted", {31'h0, busActive}, 32'h0);
    rdChk("ch0 ctrl after reset", `IDX_CH0_CTRL, 16'h0000);
    complete_run;
  end
endmodule

bind dma_ctrl dma_ctrl_checker chk (.mclk(mclk), .srst(srst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .busActive(busActive), .busAddr(busAddr), .busRdStrobe(busRdStrobe),
  .busWrStrobe(busWrStrobe), .busReady(busReady), .irqReq(irqReq));
